// ---- hw/lmr_line_monitor_readout.sv ----
// Line monitor readout: measurement registers behind an APB slave
//
// Behaviour
// - Loop voltage bit 6 is 0 when tip is above ring and 1 when below, and bit 7 reads zero.
// - Loop voltage bits 5:0 hold the unsigned loop voltage magnitude in 1.5 V steps to 94.5 V.
// - Loop current bit 6 is 0 for forward and 1 for reverse flow, and bit 7 reads zero.
// - Loop current bits 5:0 hold the unsigned current magnitude in 1.25 mA steps to 78.75 mA.
// - The tip register shows the running 8-bit tip voltage code, 0x00 at 0 V to 0xff at -95.88 V.
// - The ring register shows the running 8-bit ring voltage code on the same scale as tip.
// - Two registers each show the running 8-bit battery voltage code on that same scale.
// - Transistor 1 and 2 registers show running 8-bit current codes up to 81.35 mA.
// - With extended battery feed enabled, transistor 1 and 2 readings exclude its offset current.
// - Transistor 3 and 4 registers show running 8-bit current codes up to 9.59 mA.
`timescale 1ns/1ps
`include "lmr_map.svh"
module lmr_line_monitor_readout #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Loop voltage converter
	input  wire logic              loop_volt_sign,
	input  wire lmr_pkg::lmr_mag_t loop_volt_magnitude,
	input  wire logic              loop_volt_valid,
	// Loop current converter
	input  wire logic              loop_curr_direction,
	input  wire lmr_pkg::lmr_mag_t loop_curr_magnitude,
	input  wire logic              loop_curr_valid,
	// Tip, ring and battery converters
	input  wire lmr_pkg::lmr_code_t tip_volt_code,
	input  wire logic              tip_volt_valid,
	input  wire lmr_pkg::lmr_code_t ring_volt_code,
	input  wire logic              ring_volt_valid,
	input  wire lmr_pkg::lmr_code_t battery_volt_code_a,
	input  wire logic              battery_volt_valid_a,
	input  wire lmr_pkg::lmr_code_t battery_volt_code_b,
	input  wire logic              battery_volt_valid_b,
	// Transistor current converters
	input  wire lmr_pkg::lmr_code_t transistor1_curr_code,
	input  wire logic              transistor1_curr_valid,
	input  wire lmr_pkg::lmr_code_t transistor2_curr_code,
	input  wire logic              transistor2_curr_valid,
	input  wire lmr_pkg::lmr_code_t transistor3_curr_code,
	input  wire logic              transistor3_curr_valid,
	input  wire lmr_pkg::lmr_code_t transistor4_curr_code,
	input  wire logic              transistor4_curr_valid,
	// Extended battery feed
	input  wire lmr_pkg::lmr_code_t extended_feed_offset_current,
	output logic                   extended_battery_feed_enable
);
	import lmr_pkg::*;

	// ==========================================
	// Elaboration checks
	generate
		if (ADDR_W < `LMR_IDX_MSB + 1 || ADDR_W > 32)
		begin : g_bad_addr
			$error("lmr_line_monitor_readout: ADDR_W out of range");
		end
	endgenerate
	// Channel range and status layout must match the map constants
	generate
		if (`LMR_IDX_TR4_CURR - `LMR_IDX_LOOP_VOLT + 1 != `LMR_NUM_CH
			|| `LMR_STAT_OVR_LSB + `LMR_NUM_CH > 32)
		begin : g_bad_map
			$error("lmr_line_monitor_readout: map constants disagree");
		end
	endgenerate

	// ==========================================
	// Declarations
	lmr_apb_st_t state_r;
	lmr_apb_st_t state_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        ext_feed_r;
	logic        ext_feed_nxt;
	lmr_chmask_t fresh_r;
	lmr_chmask_t fresh_nxt;
	lmr_chmask_t ovr_r;
	lmr_chmask_t ovr_nxt;

	lmr_code_t   ch_code  [`LMR_NUM_CH];
	logic        ch_load  [`LMR_NUM_CH];
	lmr_code_t   ch_value [`LMR_NUM_CH];
	lmr_code_t   tr1_net;
	lmr_code_t   tr2_net;

	logic [31:0] addr_ext;
	logic [6:0]  acc_idx;
	logic        hi_zero;
	logic        aligned;
	logic        is_meas;
	logic        is_ctrl;
	logic        is_stat;
	logic        mapped;
	logic [6:0]  meas_off;
	logic [3:0]  meas_sel;
	logic        access;
	logic        ack_fire;
	logic        wr_fire;
	logic        rd_fire;
	logic        ctrl_wr;
	logic        stat_wr;
	lmr_chmask_t rd_clear;
	lmr_chmask_t ovr_clear;
	lmr_chmask_t ch_load_vec;
	logic [31:0] meas_rd;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;
	logic [31:0] rd_data;

	// ==========================================
	// Extended feed offset removal
	// Offset leaves the reading only while the feed is enabled
	// The correction is applied as a sample loads, so toggling the enable
	// leaves held values alone until the next conversion arrives
	// Saturation keeps a reading below the offset at zero, not wrapped
	lmr_offset_sub #(
		.W      (`LMR_CODE_W)
	) u_tr1_sub (
		.raw    (transistor1_curr_code),
		.offset (extended_feed_offset_current),
		.enable (ext_feed_r),
		.result (tr1_net)
	);

	lmr_offset_sub #(
		.W      (`LMR_CODE_W)
	) u_tr2_sub (
		.raw    (transistor2_curr_code),
		.offset (extended_feed_offset_current),
		.enable (ext_feed_r),
		.result (tr2_net)
	);

	// ==========================================
	// Channel codes, in register order
	// Loop fields: top bit forced low, sign above the magnitude
	assign ch_code[0] = {1'b0, loop_volt_sign, loop_volt_magnitude};
	assign ch_code[1] = {1'b0, loop_curr_direction, loop_curr_magnitude};
	assign ch_code[2] = tip_volt_code;
	assign ch_code[3] = ring_volt_code;
	assign ch_code[4] = battery_volt_code_a;
	assign ch_code[5] = battery_volt_code_b;
	assign ch_code[6] = tr1_net;
	assign ch_code[7] = tr2_net;
	assign ch_code[8] = transistor3_curr_code;
	assign ch_code[9] = transistor4_curr_code;

	// Converter strobes; the bus never drives these
	// A strobe may arrive every cycle; each one simply replaces the code
	assign ch_load[0] = loop_volt_valid;
	assign ch_load[1] = loop_curr_valid;
	assign ch_load[2] = tip_volt_valid;
	assign ch_load[3] = ring_volt_valid;
	assign ch_load[4] = battery_volt_valid_a;
	assign ch_load[5] = battery_volt_valid_b;
	assign ch_load[6] = transistor1_curr_valid;
	assign ch_load[7] = transistor2_curr_valid;
	assign ch_load[8] = transistor3_curr_valid;
	assign ch_load[9] = transistor4_curr_valid;

	// ==========================================
	// Holding registers, one per channel
	genvar g;
	generate
		for (g = 0; g < `LMR_NUM_CH; g++)
		begin : g_ch
			lmr_meas_if #(.W(`LMR_CODE_W)) mif ();
			assign mif.code       = ch_code[g];
			assign mif.load       = ch_load[g];
			assign ch_value[g]    = mif.value;
			assign ch_load_vec[g] = ch_load[g];
			lmr_sense_reg #(
				.W       (`LMR_CODE_W)
			) u_reg (
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.meas    (mif.dst)
			);
		end
	endgenerate

	// ==========================================
	// Address decode
	// Unaligned or out of range addresses answer with an error
	// Byte address is the register index times four
	assign addr_ext = 32'(paddr);
	assign acc_idx  = addr_ext[`LMR_IDX_MSB:`LMR_IDX_LSB];
	assign hi_zero  = ~|addr_ext[31:`LMR_IDX_MSB+1];
	assign aligned  = (addr_ext[1:0] == 2'b00);
	assign meas_off = acc_idx - `LMR_IDX_LOOP_VOLT;
	assign meas_sel = meas_off[3:0];
	assign is_meas  = hi_zero & aligned
		& (acc_idx >= `LMR_IDX_LOOP_VOLT)
		& (acc_idx <= `LMR_IDX_TR4_CURR);
	assign is_ctrl  = hi_zero & aligned & (acc_idx == `LMR_IDX_CTRL);
	assign is_stat  = hi_zero & aligned & (acc_idx == `LMR_IDX_STATUS);
	assign mapped   = is_meas | is_ctrl | is_stat;

	// ==========================================
	// Transfer qualifiers
	// First access cycle is taken; the ack edge commits a write
	assign access   = psel & penable & (state_r == LMR_ST_IDLE);
	assign ack_fire = psel & penable & (state_r == LMR_ST_ACK);
	assign wr_fire  = ack_fire & pwrite;
	// A read acts on the edge that captures its data, so the data and
	// the fresh flag it clears always describe the same sample
	assign rd_fire  = access & ~pwrite;
	// Only lane 0 carries control bits
	assign ctrl_wr  = wr_fire & is_ctrl & pstrb[0];
	assign stat_wr  = wr_fire & is_stat;

	// ==========================================
	// Read data
	// Narrow registers sit in the low byte, upper bits read zero
	assign meas_rd  = is_meas ? {24'h000000, ch_value[meas_sel]} : 32'h00000000;
	assign ctrl_rd  = {31'h00000000, ext_feed_r};
	assign stat_rd  = {6'h00, ovr_r, 6'h00, fresh_r};
	assign rd_data  = is_meas ? meas_rd
		: (is_ctrl ? ctrl_rd
		: (is_stat ? stat_rd : 32'h00000000));

	// ==========================================
	// Bus response
	// Data is captured on the first access edge and shown for one cycle;
	// the fixed wait state keeps the read path a single register stage
	// Unmapped places answer with an error and zero data, never a hang
	always_comb
	begin
		state_nxt   = state_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		case (state_r)
			LMR_ST_IDLE:
			begin
				if (access)
				begin
					state_nxt   = LMR_ST_ACK;
					pready_nxt  = 1'b1;
					pslverr_nxt = ~mapped;
					prdata_nxt  = (mapped & ~pwrite) ? rd_data : 32'h00000000;
				end
			end
			LMR_ST_ACK:
			begin
				state_nxt  = LMR_ST_IDLE;
				prdata_nxt = 32'h00000000;
			end
			default:
			begin
				state_nxt  = LMR_ST_IDLE;
				prdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_r   <= LMR_ST_IDLE;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ==========================================
	// Control register
	// Measurement writes fall through here with no effect
	assign ext_feed_nxt = ctrl_wr ? pwdata[`LMR_CTRL_EXT_BIT] : ext_feed_r;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ext_feed_r <= `LMR_CTRL_RESET;
		else
			ext_feed_r <= ext_feed_nxt;
	end

	// ==========================================
	// Fresh and overrun flags
	// A sample in the clearing cycle wins, so no update goes unseen
	// Overrun only counts loads that overwrite a sample nobody has read;
	// software clears it by writing ones, and a new overrun still wins
	generate
		for (g = 0; g < `LMR_NUM_CH; g++)
		begin : g_flag
			assign rd_clear[g]  = rd_fire & is_meas & (meas_sel == 4'(g));
			assign ovr_clear[g] = stat_wr & pwdata[`LMR_STAT_OVR_LSB + g];
			assign fresh_nxt[g] = ch_load_vec[g] | (fresh_r[g] & ~rd_clear[g]);
			assign ovr_nxt[g]   = (ch_load_vec[g] & fresh_r[g] & ~rd_clear[g])
				| (ovr_r[g] & ~ovr_clear[g]);
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fresh_r <= '0;
			ovr_r   <= '0;
		end
		else
		begin
			fresh_r <= fresh_nxt;
			ovr_r   <= ovr_nxt;
		end
	end

	// ==========================================
	// Outputs, each straight from a flop
	// No logic after these flops, so outputs change only on clock edges
	assign prdata                       = prdata_r;
	assign pready                       = pready_r;
	assign pslverr                      = pslverr_r;
	assign extended_battery_feed_enable = ext_feed_r;

endmodule : lmr_line_monitor_readout

// ---- hw/lmr_map.svh ----
// Register map, field positions and reset values of the line monitor readout
`ifndef LMR_MAP_SVH
`define LMR_MAP_SVH
// ==========================================
// Register indices (byte address is index times four)
`define LMR_IDX_LOOP_VOLT  7'h4e
`define LMR_IDX_LOOP_CURR  7'h4f
`define LMR_IDX_TIP_VOLT   7'h50
`define LMR_IDX_RING_VOLT  7'h51
`define LMR_IDX_BAT_VOLT_A 7'h52
`define LMR_IDX_BAT_VOLT_B 7'h53
`define LMR_IDX_TR1_CURR   7'h54
`define LMR_IDX_TR2_CURR   7'h55
`define LMR_IDX_TR3_CURR   7'h56
`define LMR_IDX_TR4_CURR   7'h57
`define LMR_IDX_CTRL       7'h60
`define LMR_IDX_STATUS     7'h61
// ==========================================
// Address decode
`define LMR_IDX_LSB        2
`define LMR_IDX_MSB        8
// ==========================================
// Fields
`define LMR_NUM_CH         10
`define LMR_SIGN_BIT       6
`define LMR_MAG_W          6
`define LMR_CODE_W         8
`define LMR_CTRL_EXT_BIT   0
`define LMR_STAT_OVR_LSB   16
// ==========================================
// Reset values
`define LMR_MEAS_RESET     8'h00
`define LMR_CTRL_RESET     1'b0
`endif

// ---- hw/lmr_pkg.sv ----
// Types shared by the line monitor readout modules
package lmr_pkg;
	// Bus response state
	typedef enum logic [0:0]
	{
		LMR_ST_IDLE = 1'b0,
		LMR_ST_ACK  = 1'b1
	} lmr_apb_st_t;
	// One measurement code
	typedef logic [7:0] lmr_code_t;
	// One bit per measurement channel
	typedef logic [9:0] lmr_chmask_t;
	// Loop magnitude field
	typedef logic [5:0] lmr_mag_t;
endpackage : lmr_pkg

// ---- hw/lmr_meas_if.sv ----
// Carrier between the top and one measurement holding register
`timescale 1ns/1ps
interface lmr_meas_if #(
	parameter int W = 8
);
	logic [W-1:0] code;
	logic         load;
	logic [W-1:0] value;
	modport src (output code, output load, input value);
	modport dst (input code, input load, output value);
endinterface : lmr_meas_if

// ---- hw/lmr_sense_reg.sv ----
// Holding register for one measurement channel
`timescale 1ns/1ps
`include "lmr_map.svh"
module lmr_sense_reg #(
	parameter int W = 8
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	lmr_meas_if.dst   meas
);
	import lmr_pkg::*;
	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;
	generate
		if (W < 1 || W > 32)
		begin : g_bad_w
			$error("lmr_sense_reg: W out of range");
		end
	endgenerate
	// New code replaces the held one on its strobe only
	assign value_nxt  = meas.load ? meas.code : value_r;
	assign meas.value = value_r;
	// Holding register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			value_r <= W'(`LMR_MEAS_RESET);
		else
			value_r <= value_nxt;
	end
endmodule : lmr_sense_reg

// ---- hw/lmr_offset_sub.sv ----
// Removes the extended feed offset from a transistor current code
`timescale 1ns/1ps
module lmr_offset_sub #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] raw,
	input  wire logic [W-1:0] offset,
	input  wire logic         enable,
	output wire logic [W-1:0] result
);
	logic [W:0] diff;
	logic       under;
	generate
		if (W < 1 || W > 31)
		begin : g_bad_w
			$error("lmr_offset_sub: W out of range");
		end
	endgenerate
	// Saturate at zero so a small reading never wraps to full scale
	assign diff   = {1'b0, raw} - {1'b0, offset};
	assign under  = diff[W];
	assign result = !enable ? raw : (under ? '0 : diff[W-1:0]);
endmodule : lmr_offset_sub

// ---- verif/lmr_readout_props.sv ----
// Concurrent checks on the readout register port
`timescale 1ns/1ps
module lmr_readout_props #(
	parameter int ADDR_W = 12
) (
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              extended_battery_feed_enable
);
	// ==========================================
	// Decode helpers
	wire rd_ack  = pready && !pwrite;
	wire in_meas = paddr >= 'h138 && paddr <= 'h15c && paddr[1:0] == 2'b00;
	wire ctl_wr  = pready && pwrite && paddr == 'h180;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Bus timing: one wait state, one-cycle answer
	ack_after_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after wait state");
	ack_one_cycle_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	error_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer");
	// ==========================================
	// Field layout of the sense registers
	loop_volt_top_a: assert property (rd_ack && paddr == 'h138 |-> prdata[31:7] == 25'h0)
		else $error("loop voltage upper bits set");
	loop_curr_top_a: assert property (rd_ack && paddr == 'h13c |-> prdata[31:7] == 25'h0)
		else $error("loop current upper bits set");
	meas_byte_only_a: assert property (rd_ack && in_meas |-> prdata[31:8] == 24'h0)
		else $error("sense code wider than a byte");
	meas_write_quiet_a: assert property (pready && pwrite && in_meas |-> !pslverr)
		else $error("write to sense register refused");
	// Enable only moves on a control write, and takes bit 0
	ctrl_take_a: assert property ($changed(extended_battery_feed_enable) |->
		$past(ctl_wr) && extended_battery_feed_enable == $past(pwdata[0]))
		else $error("feed enable changed without write");
endmodule : lmr_readout_props

// ---- verif/lmr_line_monitor_readout_tb_top.sv ----
// Self-checking bench for the line monitor readout
`timescale 1ns/1ps
module lmr_line_monitor_readout_tb_top;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_en;
	logic [7:0]  cd [10] = '{default: 8'h00};
	logic [9:0]  vld     = 10'h000;
	logic [7:0]  ofs     = 8'h00;
	logic [7:0]  expv [10] = '{default: 8'h00};
	logic [32:0] q [$];
	logic [32:0] e;
	logic        en = 1'b0;
	int          miscompares = 0;
	int          n_compared  = 0;
	int          cyc  = 0;
	int          seed = 32'hd8e8;
	// ==========================================
	// Clock and device
	always #20 clk_sys = ~clk_sys;
	lmr_line_monitor_readout u_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.loop_volt_sign(cd[0][6]), .loop_volt_magnitude(cd[0][5:0]), .loop_volt_valid(vld[0]),
		.loop_curr_direction(cd[1][6]), .loop_curr_magnitude(cd[1][5:0]),
		.loop_curr_valid(vld[1]),
		.tip_volt_code(cd[2]), .tip_volt_valid(vld[2]),
		.ring_volt_code(cd[3]), .ring_volt_valid(vld[3]),
		.battery_volt_code_a(cd[4]), .battery_volt_valid_a(vld[4]),
		.battery_volt_code_b(cd[5]), .battery_volt_valid_b(vld[5]),
		.transistor1_curr_code(cd[6]), .transistor1_curr_valid(vld[6]),
		.transistor2_curr_code(cd[7]), .transistor2_curr_valid(vld[7]),
		.transistor3_curr_code(cd[8]), .transistor3_curr_valid(vld[8]),
		.transistor4_curr_code(cd[9]), .transistor4_curr_valid(vld[9]),
		.extended_feed_offset_current(ofs), .extended_battery_feed_enable(ext_en)
	);
	// ==========================================
	// Reporting
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t answer %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// ==========================================
	// Bus master: request held until ready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] x);
		q.push_back(x);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	// Converter samples; some channels skip a load to show holding
	task automatic load(input bit all);
		logic [9:0] m;
		logic [7:0] r;
		logic [7:0] o;
		m = all ? 10'h3ff : 10'($random(seed));
		o = 8'($random(seed));
		ofs <= o;
		for (int i = 0; i < 10; i++)
		begin
			r = all ? 8'hff : 8'($random(seed));
			cd[i] <= r;
			if (m[i])
				expv[i] = (i < 2) ? {1'b0, r[6:0]} :
					(i > 5 && i < 8 && en) ? ((r > o) ? r - o : 8'h00) : r;
		end
		vld <= m;
		@(posedge clk_sys);
		vld <= 10'h000;
	endtask : load
	// ==========================================
	// Answer watcher: oldest note against each answer
	always @(posedge clk_sys)
	begin
		if (pready === 1'b1)
		begin
			e = (q.size() > 0) ? q.pop_front() : 33'h1_dead_beef;
			if (pwrite)
				check({pslverr, 32'h0}, {e[32], 32'h0});
			else
				check({pslverr, prdata}, e);
		end
	end
	// Hang guard, far above the expected run length
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		// Reset values, then unmapped and unaligned places
		for (int i = 0; i < 10; i++)
			apb(1'b0, 12'h138 + 12'(4 * i), 32'h0, {25'h0, expv[i]});
		apb(1'b0, 12'h3fc, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'h139, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h3fc, 32'h1, {1'b1, 32'h0});
		// Toggle the feed enable, load, then try to overwrite each code
		for (int n = 0; n < 16; n++)
		begin
			en = n[0];
			apb(1'b1, 12'h180, {31'h0, en}, 33'h0);
			apb(1'b0, 12'h180, 32'h0, {32'h0, en});
			check({32'h0, ext_en}, {32'h0, en});
			load(n == 0);
			for (int i = 0; i < 10; i++)
			begin
				apb(1'b1, 12'h138 + 12'(4 * i), 32'($random(seed)), 33'h0);
				apb(1'b0, 12'h138 + 12'(4 * i), 32'h0, {25'h0, expv[i]});
			end
		end
		// Status: fresh per load, overrun on a second unread load, read clears
		load(1'b1);
		apb(1'b0, 12'h184, 32'h0, {1'b0, 32'h000003ff});
		load(1'b1);
		apb(1'b0, 12'h184, 32'h0, {1'b0, 32'h03ff03ff});
		apb(1'b1, 12'h184, 32'h03ff0000, 33'h0);
		apb(1'b0, 12'h140, 32'h0, {25'h0, expv[2]});
		apb(1'b0, 12'h184, 32'h0, {1'b0, 32'h000003fb});
		finish_test();
	end
endmodule : lmr_line_monitor_readout_tb_top
bind lmr_line_monitor_readout lmr_readout_props #(.ADDR_W(ADDR_W)) u_props (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.extended_battery_feed_enable(extended_battery_feed_enable)
);
